// ===== logic/piu_pkg.sv
// Constants shared by the eight-level priority interrupt unit.
package piu_pkg;

  // ****************************************************************
  // Processor instruction codes (18-bit words).
  // ****************************************************************
  localparam logic [17:0] CODE_RELEASE = 18'h386C4; // Release top level.
  localparam logic [17:0] CODE_REL_RESTORE = 18'h386E4; // Release, restore.
  localparam logic [17:0] CODE_RESTORE = 18'h38FE2; // Arm restore only.
  localparam logic [17:0] CODE_SKIP = 18'h38B41; // Skip on inactive.
  localparam logic [17:0] CODE_READ_STATUS = 18'h38B4A; // Read status.
  localparam logic [17:0] CODE_INITIATE = 18'h38B44; // Initiate activity.

  // ****************************************************************
  // Control and status word layout (bit 00 is the word's MSB).
  // ****************************************************************
  localparam int unsigned W_ENABLE = 17; // Enable bit (bit 00).
  localparam int unsigned W_REQ_HI = 15; // Requests 0..7 (bits 02-09).
  localparam int unsigned W_REQ_LO = 8;
  localparam int unsigned W_PL_HI = 7; // Levels 0..7 (bits 10-17).
  localparam int unsigned W_PL_LO = 0;

  // ****************************************************************
  // Levels, vectors and timing.
  // ****************************************************************
  localparam logic [2:0] LVL_PROG_INT = 3'h3; // Level for program int.
  localparam logic [2:0] LVL_SW_FIRST = 3'h4; // First software level.
  localparam logic [14:0] SW_VEC_BASE = 15'h0020; // Software channels.
  localparam logic [1:0] IOT_HOLD = 2'h2; // Own + following instr.

  // ****************************************************************
  // Register map on the AXI4-Lite slave.
  // ****************************************************************
  localparam logic [3:0] OFS_STATUS = 4'h0; // Status word, read only.
  localparam logic [3:0] OFS_INITIATE = 4'h4; // Write runs initiate.
  localparam logic [3:0] OFS_GRANT = 4'h8; // Last grant, read only.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Break sequencer states.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BRK = 1'b1
  } piu_state_t;

endpackage

// ===== logic/piu_top.sv
// Eight-level priority interrupt unit with an AXI4-Lite register slave.
module piu_top
  import piu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] dev_req, // Hardware request lines, levels 0-3.
  input wire logic [14:0] dev_vector, // Vector of winning peripheral.
  input wire logic iot_valid, // One-cycle pulse per I/O instruction.
  input wire logic [17:0] iot_code,
  input wire logic [17:0] accumulator,
  input wire logic instr_done, // Pulse at each instruction end.
  input wire logic brk_ack, // Processor stopped and takes break.
  input wire logic pi_taken, // Ordinary program interrupt taken.
  input wire logic indirect_ref, // Indirect reference executing.
  output logic brk_req_r,
  output logic [14:0] vector_r,
  output logic vec_valid_r,
  output logic iot_skip_r,
  output logic [17:0] iot_data_r,
  output logic iot_data_valid_r,
  output logic restore_r,
  output logic pi_req_r,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Reverses an 8-bit field; the word numbers bits from the MSB.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Lowest set index (highest priority) with a found flag on top.
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Bit i is set when any level i or more urgent is set.
  function automatic logic [7:0] at_or_above(input logic [7:0] v);
    logic [7:0] r;
    logic acc;
    r = '0;
    acc = 1'b0;
    for (int i = 0; i < 8; i++) begin
      acc = acc | v[i];
      r[i] = acc;
    end
    return r;
  endfunction

  // ****************************************************************
  // State and decode.
  // ****************************************************************
  logic [3:0] req_s1_r, req_s2_r; // Synchroniser for request pins.
  logic [14:0] vec_s1_r, vec_s2_r; // Synchroniser for vector pins.
  logic [7:0] rr_r, rr_nxt; // Request register, bit n is level n.
  logic [7:0] pl_r, pl_nxt; // Priority level register.
  logic en_r; // Priority system enable.
  logic [1:0] hold_r; // Instructions left before a grant.
  logic [2:0] gnt_lvl_r; // Level of the latest grant.
  piu_state_t st_r, st_nxt;
  logic [7:0] blk_mask, accept;
  logic [3:0] cand, top;
  logic go, grant, isa_fire, rel_fire, dbr_fire, res_fire;
  logic [17:0] isa_ac, status_w;
  logic aw_got_r, w_got_r, axi_isa; // Write channel bookkeeping.
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;

  assign blk_mask = at_or_above(pl_r);
  assign accept = rr_r & ~blk_mask;
  assign cand = first_set(accept);
  assign top = first_set(pl_r);
  // An I/O instruction in its own cycle blocks a grant as well, since
  // the hold count only loads at the edge that takes the instruction.
  assign go = en_r & cand[3] & (hold_r == 2'h0) & ~iot_valid;
  assign grant = (st_r == ST_BRK) & brk_ack & go;
  assign rel_fire = iot_valid & (iot_code == CODE_RELEASE);
  assign dbr_fire = iot_valid & (iot_code == CODE_REL_RESTORE);
  assign res_fire = iot_valid & (iot_code == CODE_RESTORE);
  // Register writes of the initiate word wait for a quiet IO_TRANSFER_INSTRUCTION cycle.
  assign axi_isa = aw_got_r & w_got_r & ~s_axi_bvalid & ~iot_valid &
                   (aw_addr_r == OFS_INITIATE);
  assign isa_fire = (iot_valid & (iot_code == CODE_INITIATE)) | axi_isa;
  assign isa_ac = iot_valid ? accumulator : w_data_r[17:0];
  assign status_w = {en_r, 1'b0, rev8(rr_r), rev8(pl_r)};

  // ****************************************************************
  // Pin synchronisers; the first stage feeds only the second.
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_s1_r <= '0;
      req_s2_r <= '0;
      vec_s1_r <= '0;
      vec_s2_r <= '0;
    end else begin
      req_s1_r <= dev_req;
      req_s2_r <= req_s1_r;
      vec_s1_r <= dev_vector;
      vec_s2_r <= vec_s1_r;
    end
  end

  // ****************************************************************
  // Request and level updates; sets are applied after clears.
  // ****************************************************************
  always_comb begin
    rr_nxt = rr_r;
    pl_nxt = pl_r;
    if ((rel_fire | dbr_fire) & top[3]) begin
      pl_nxt[top[2:0]] = 1'b0;
    end
    if (dbr_fire & top[3]) begin
      rr_nxt[top[2:0]] = 1'b0;
    end
    rr_nxt[3:0] = rr_nxt[3:0] | req_s2_r;
    if (isa_fire) begin
      rr_nxt = rr_nxt | rev8(isa_ac[W_REQ_HI:W_REQ_LO]);
      // A raise is honoured only above every active level.
      pl_nxt = pl_nxt |
               (rev8(isa_ac[W_PL_HI:W_PL_LO]) & ~blk_mask);
    end
    if (grant) begin
      pl_nxt[cand[2:0]] = 1'b1;
    end
    if (pi_taken) begin
      pl_nxt[LVL_PROG_INT] = 1'b1;
    end
  end

  // Stores the request and level registers and the enable.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rr_r <= '0;
      pl_r <= '0;
      en_r <= 1'b0;
    end else begin
      rr_r <= rr_nxt;
      pl_r <= pl_nxt;
      if (isa_fire) begin
        en_r <= isa_ac[W_ENABLE];
      end
    end
  end

  // Counts the IO_TRANSFER_INSTRUCTION's own end and the next instruction's end.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_r <= '0;
    end else if (iot_valid) begin
      hold_r <= IOT_HOLD;
    end else if (instr_done && hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  // ****************************************************************
  // Break sequencer: ask for the halt, then inject the vector.
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (go) begin
          st_nxt = ST_BRK;
        end
      end
      ST_BRK: begin
        // The request may vanish while waiting; then drop the halt.
        if (brk_ack || !go) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Holds the state and the halt line in step.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      brk_req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      brk_req_r <= (st_nxt == ST_BRK);
    end
  end

  // Presents the vector for one cycle on the grant.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vector_r <= '0;
      vec_valid_r <= 1'b0;
      gnt_lvl_r <= '0;
    end else begin
      vec_valid_r <= grant;
      if (grant) begin
        gnt_lvl_r <= cand[2:0];
        // Hardware levels carry the bus-nearest device's vector.
        if (cand[2:0] < LVL_SW_FIRST) begin
          vector_r <= vec_s2_r;
        end else begin
          vector_r <= SW_VEC_BASE + 15'(cand[2:0] - LVL_SW_FIRST);
        end
      end
    end
  end

  // ****************************************************************
  // Instruction answers, restore arming and program interrupt path.
  // ****************************************************************
  logic res_arm_r; // Restoration pending for next indirect reference.

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      iot_skip_r <= 1'b0;
      iot_data_r <= '0;
      iot_data_valid_r <= 1'b0;
    end else begin
      iot_skip_r <= iot_valid && iot_code == CODE_SKIP &&
                    ((accumulator[W_ENABLE] & en_r) ||
                     |(rev8(accumulator[W_PL_HI:W_PL_LO]) &
                       ~blk_mask));
      iot_data_valid_r <= iot_valid && iot_code == CODE_READ_STATUS;
      if (iot_valid && iot_code == CODE_READ_STATUS) begin
        iot_data_r <= status_w;
      end
    end
  end

  // The arm survives until an indirect reference consumes it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      res_arm_r <= 1'b0;
      restore_r <= 1'b0;
    end else begin
      restore_r <= res_arm_r & indirect_ref;
      if (dbr_fire || res_fire) begin
        res_arm_r <= 1'b1;
      end else if (indirect_ref) begin
        res_arm_r <= 1'b0;
      end
    end
  end

  // With the system disabled, hardware requests go the ordinary way.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pi_req_r <= 1'b0;
    end else begin
      pi_req_r <= ~en_r & (|req_s2_r);
    end
  end

  // ****************************************************************
  // AXI4-Lite slave: one write and one read at a time.
  // ****************************************************************
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Collects address and data in either order, then answers.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid &&
          (axi_isa || aw_addr_r != OFS_INITIATE)) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == OFS_INITIATE) ? RESP_OKAY
                       : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_STATUS: s_axi_rdata <= {14'h0000, status_w};
        OFS_GRANT: s_axi_rdata <= {14'h0000, gnt_lvl_r, vector_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_grant_sets_level: assert property (@(posedge sys_clk)
    disable iff (sys_rst) vec_valid_r |-> pl_r[gnt_lvl_r])
    else $error("granted level not set in priority register");
  a_grant_not_masked: assert property (@(posedge sys_clk)
    disable iff (sys_rst) grant |-> !blk_mask[cand[2:0]] && rr_r[cand[2:0]])
    else $error("grant given to a masked or absent level");
  a_halt_on_request: assert property (@(posedge sys_clk)
    disable iff (sys_rst) (st_r == ST_IDLE && go) |=> brk_req_r)
    else $error("no halt request for acceptable level");
  a_iot_blocks_grant: assert property (@(posedge sys_clk)
    disable iff (sys_rst) iot_valid |=> !vec_valid_r ##1 !vec_valid_r)
    else $error("grant followed an I/O instruction too soon");
  a_release_arms: assert property (@(posedge sys_clk)
    disable iff (sys_rst) dbr_fire |=> res_arm_r)
    else $error("release-and-restore did not arm restoration");
  a_restore_keeps_pl: assert property (@(posedge sys_clk)
    disable iff (sys_rst) (res_fire && !grant && !pi_taken)
    |=> pl_r == $past(pl_r))
    else $error("restore changed the priority levels");
  a_status_read: assert property (@(posedge sys_clk)
    disable iff (sys_rst) (iot_valid && iot_code == CODE_READ_STATUS)
    |=> iot_data_valid_r && iot_data_r == $past(status_w))
    else $error("status word not returned");
  a_prog_int_level: assert property (@(posedge sys_clk)
    disable iff (sys_rst) pi_taken |=> pl_r[LVL_PROG_INT])
    else $error("program interrupt did not set level 3");
  a_release_drops: assert property (@(posedge sys_clk)
    disable iff (sys_rst) (rel_fire && top[3] && !pi_taken && !isa_fire)
    |=> !pl_r[$past(top[2:0])] && (!res_arm_r || $past(res_arm_r)))
    else $error("release did not drop the top level");

endmodule // piu_top

// ===== sim/piu_cpu_model.sv
// Processor core and bus peripherals as seen from the interrupt unit.
module piu_cpu_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic brk_req_r,
  input wire logic pi_req_r,
  input wire logic [3:0] pin_req,
  input wire logic [1:0] l1_dev,
  input wire logic [14:0] vec_near,
  input wire logic [14:0] vec_far,
  output logic instr_done,
  output logic brk_ack,
  output logic pi_taken,
  output logic [3:0] dev_req,
  output logic [14:0] dev_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_r; // Cycle within a four-cycle instruction.
  logic pi_seen_r; // The ordinary interrupt was taken for this request.
  logic [14:0] noise_r; // Vector lines that no device drives.

  // Each instruction takes four cycles; idle vector lines keep toggling.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= 2'h0;
      noise_r <= 15'h5555;
    end else begin
      phase_r <= phase_r + 2'h1;
      noise_r <= ~noise_r;
    end
  end

  // One ordinary interrupt per rise of the routed request.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !pi_req_r) begin
      pi_seen_r <= 1'b0;
    end else if (pi_taken) begin
      pi_seen_r <= 1'b1;
    end
  end

  assign instr_done = (phase_r == 2'h3);
  // The core stops only at an instruction boundary, then takes the break.
  assign brk_ack = instr_done & brk_req_r;
  assign pi_taken = instr_done & pi_req_r & ~pi_seen_r;
  // Two devices share level 1; the one nearer the core wins the chain.
  assign dev_req = pin_req | {2'h0, |l1_dev, 1'b0};
  assign dev_vector = l1_dev[0] ? vec_near :
                      (l1_dev[1] ? vec_far : noise_r);
endmodule // piu_cpu_model

// ===== sim/tb_priority_interrupt_unit.sv
// Self-checking bench for the priority interrupt unit.
module tb_priority_interrupt_unit
  import piu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, iot_valid = 1'b0;
  logic indirect_ref = 1'b0;
  logic [17:0] iot_code = 18'h0, accumulator = 18'h0, iot_data_r;
  logic [3:0] dev_req, pin_req = 4'h0, s_axi_wstrb = 4'hF;
  logic [14:0] dev_vector, vector_r, vec_near = 15'h0, vec_far = 15'h0;
  logic [1:0] l1_dev = 2'h0, s_axi_bresp, s_axi_rresp;
  logic instr_done, brk_ack, pi_taken, brk_req_r, vec_valid_r, iot_skip_r;
  logic iot_data_valid_r, restore_r, pi_req_r;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h9A44;
  int err_total = 0, n_compared = 0, n_restore = 0;
  // Expected results wait here until the monitor sees them appear.
  logic [35:0] q_stat[$];
  logic [14:0] q_vec[$];
  logic q_skip[$];
  logic [65:0] q_axi[$];
  logic skip_due = 1'b0;
  logic halt_seen = 1'b0; // Halt request seen since the last grant.

  piu_top i_piu_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .dev_req(dev_req), .dev_vector(dev_vector),
    .iot_valid(iot_valid), .iot_code(iot_code),
    .accumulator(accumulator), .instr_done(instr_done),
    .brk_ack(brk_ack), .pi_taken(pi_taken),
    .indirect_ref(indirect_ref), .brk_req_r(brk_req_r),
    .vector_r(vector_r), .vec_valid_r(vec_valid_r),
    .iot_skip_r(iot_skip_r), .iot_data_r(iot_data_r),
    .iot_data_valid_r(iot_data_valid_r), .restore_r(restore_r),
    .pi_req_r(pi_req_r),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  piu_cpu_model i_piu_cpu_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .brk_req_r(brk_req_r), .pi_req_r(pi_req_r),
    .pin_req(pin_req), .l1_dev(l1_dev),
    .vec_near(vec_near), .vec_far(vec_far),
    .instr_done(instr_done), .brk_ack(brk_ack),
    .pi_taken(pi_taken), .dev_req(dev_req),
    .dev_vector(dev_vector)
  );

  always #5 sys_clk = ~sys_clk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One I/O instruction, then time for its answer to land.
  task automatic io_transfer_instruction(input logic [17:0] code, input logic [17:0] ac);
    iot_valid <= 1'b1;
    iot_code <= code;
    accumulator <= ac;
    @(posedge sys_clk);
    iot_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic stat(input logic [17:0] m, input logic [17:0] v);
    q_stat.push_back({m, v});
    io_transfer_instruction(CODE_READ_STATUS, 18'h0);
  endtask

  task automatic skp(input logic [17:0] ac, input logic e);
    q_skip.push_back(e);
    io_transfer_instruction(CODE_SKIP, ac);
  endtask

  // An indirect reference; restoration pulses are counted by the monitor.
  task automatic ind(input int cnt);
    indirect_ref <= 1'b1;
    @(posedge sys_clk);
    indirect_ref <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(34'(n_restore), 34'(cnt));
  endtask

  task automatic wait_grant();
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      if (vec_valid_r === 1'b1) break;
    end
    @(posedge sys_clk);
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    q_axi.push_back({32'h0, r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    // One idle edge keeps a following call off this release.
    @(posedge sys_clk);
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] m,
                     input logic [33:0] e);
    q_axi.push_back({m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    // One idle edge keeps a following call off this release.
    @(posedge sys_clk);
  endtask

  // ****************************************************************
  // Monitor: each result that appears takes the oldest expectation.
  // ****************************************************************
  always @(posedge sys_clk) begin
    logic [65:0] e;
    if (skip_due) check(iot_skip_r, q_skip.pop_front());
    skip_due = (iot_valid === 1'b1) && (iot_code === CODE_SKIP);
    if (iot_data_valid_r === 1'b1) begin
      e = q_stat.pop_front();
      check(iot_data_r & e[35:18], e[17:0]);
    end
    if (vec_valid_r === 1'b1) begin
      check(vector_r, q_vec.pop_front());
      check(halt_seen, 1'b1);
      check(brk_req_r, 1'b0);
      halt_seen = 1'b0;
    end
    if (brk_req_r === 1'b1) halt_seen = 1'b1;
    if (restore_r === 1'b1) n_restore++;
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
      e = q_axi.pop_front();
      check({s_axi_rresp, s_axi_rdata & e[65:34]}, e[33:0]);
    end
    if ((s_axi_bvalid & s_axi_bready) === 1'b1) begin
      e = q_axi.pop_front();
      check({s_axi_bresp, 32'h0}, e[33:0]);
    end
  end

  // A hang counts as a mismatch and ends the run the usual way.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    seed = lfsr(seed);
    vec_near <= seed[14:0];
    seed = lfsr(seed);
    vec_far <= seed[14:0];
    @(posedge sys_clk);
    stat(18'h3FFFF, 18'h00000);
    q_vec.push_back(15'h0021);
    io_transfer_instruction(CODE_INITIATE, 18'h20400);
    wait_grant();
    stat(18'h3FFFF, 18'h20404);
    q_vec.push_back(vec_near);
    l1_dev <= 2'h3;
    wait_grant();
    l1_dev <= 2'h0;
    stat(18'h3FFFF, 18'h24444);
    for (int n = 0; n < 8; n++) skp(18'h1 << (7 - n), n == 0);
    skp(18'h20000, 1'b1);
    skp(18'h00000, 1'b0);
    io_transfer_instruction(CODE_REL_RESTORE, 18'h0);
    ind(1);
    stat(18'h3FFFF, 18'h20404);
    io_transfer_instruction(CODE_INITIATE, 18'h20020);
    stat(18'h3FFFF, 18'h20424);
    io_transfer_instruction(CODE_INITIATE, 18'h20002);
    stat(18'h3FFFF, 18'h20424);
    skp(18'h00040, 1'b1);
    io_transfer_instruction(CODE_RELEASE, 18'h0);
    ind(1);
    stat(18'h3FFFF, 18'h20404);
    io_transfer_instruction(CODE_RESTORE, 18'h0);
    ind(2);
    stat(18'h3FFFF, 18'h20404);
    io_transfer_instruction(CODE_REL_RESTORE, 18'h0);
    ind(3);
    stat(18'h3FFFF, 18'h20000);
    axr(4'h0, 32'h3FFFF, {RESP_OKAY, 32'h20000});
    axr(4'hC, 32'h0, {RESP_SLVERR, 32'h0});
    axw(4'h0, 32'h0, RESP_SLVERR);
    q_vec.push_back(15'h0023);
    axw(4'h4, 32'h00020100, RESP_OKAY);
    wait_grant();
    axr(4'h8, 32'h3FFFF, {RESP_OKAY, 32'h38023});
    io_transfer_instruction(CODE_REL_RESTORE, 18'h0);
    ind(4);
    stat(18'h3FFFF, 18'h20000);
    io_transfer_instruction(CODE_INITIATE, 18'h00000);
    pin_req <= 4'h4;
    repeat (20) @(posedge sys_clk);
    check(pi_req_r, 1'b1);
    stat(18'h200FF, 18'h00010);
    pin_req <= 4'h0;
    check(34'(q_vec.size() + q_stat.size() + q_axi.size()), 34'h0);
    results();
  end
endmodule // tb_priority_interrupt_unit
